/* rtl/peripheral_control_register_file.sv */
// Nibble register file: control registers plus data memory alias window
//
// Notes on behaviour
// - Nibble addressing, rows 0-7, columns 0-15
// - Locations 00h-3fh are peripheral control registers
// - Locations 40h-7fh alias current data memory bank
// - Read instruction copies location into window register
// - Write instruction stores window nibble into location
// - Only 61 control nibbles exist, three unused
// - Unused reads undefined, writes change nothing
// - Each nibble R/W, RO, WO or read-clear
// - Writes to read-only nibbles have no effect
// - Write-only reads undefined, setting kept intact
// - Forced-zero bits always read zero
`timescale 1ns/100ps
module peripheral_control_register_file
   import rf_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire rf_req_t i_req,
   input wire logic [CTRL_BITS-1:0] i_status,
   input wire logic [NIB_W-1:0] i_dmem_rdata,
   output logic [NIB_W-1:0] o_window_data,
   output logic o_window_load,
   output logic o_busy,
   output dmem_req_t o_dmem,
   output logic [CTRL_BITS-1:0] o_ctrl
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_MEM_ISSUE,
      ST_MEM_CAPTURE
   } seq_state_t;

   seq_state_t state_reg;
   logic [NIB_W-1:0] ctrl_reg [CTRL_NIBS];
   logic [NIB_W-1:0] ctrl_next [CTRL_NIBS];
   logic take_rd;
   logic take_wr;
   logic is_alias;
   logic [5:0] nib_idx;
   logic [NIB_W-1:0] rd_nibble;
   logic [NIB_W-1:0] wdata_reg;
   logic [NIB_W-1:0] window_reg;
   logic load_reg;
   logic [ADDR_W-1:0] mem_addr_reg;
   logic mem_rd_reg;
   logic mem_wr_reg;

   // Requests are taken only while idle; a read beats a write in one cycle
   assign take_rd = i_req.rd && (state_reg == ST_IDLE);
   assign take_wr = i_req.wr && !i_req.rd && (state_reg == ST_IDLE);
   // Row in bits 6:4, column in bits 3:0
   assign is_alias = i_req.addr[ALIAS_BIT];
   assign nib_idx = i_req.addr[5:0];

   // Read value of the addressed control nibble
   always_comb begin
      logic [CTRL_BITS-1:0] vis;
      vis = '0;
      for (int k = 0; k < CTRL_NIBS; k++) begin
         vis[k*NIB_W +: NIB_W] = (ctrl_reg[k] & (RD_MASK[k*NIB_W +: NIB_W]
                                 | RC_MASK[k*NIB_W +: NIB_W]))
                                 | (i_status[k*NIB_W +: NIB_W] & HW_MASK[k*NIB_W +: NIB_W]);
      end
      // Unused and write-only bits read as a fixed pattern
      if (!IMPL_MAP[nib_idx]) begin
         rd_nibble = UNDEF_READ;
      end else begin
         rd_nibble = vis[nib_idx*NIB_W +: NIB_W];
      end
   end

   // Next value of every control nibble
   generate
      for (genvar g = 0; g < CTRL_NIBS; g++) begin : g_nib
         localparam logic [NIB_W-1:0] WM = WR_MASK[g*NIB_W +: NIB_W];
         localparam logic [NIB_W-1:0] RCM = RC_MASK[g*NIB_W +: NIB_W];
         logic hit_wr;
         logic hit_rd;
         assign hit_wr = take_wr && !is_alias && (nib_idx == 6'(g)) && IMPL_MAP[g];
         assign hit_rd = take_rd && !is_alias && (nib_idx == 6'(g));
         always_comb begin
            ctrl_next[g] = ctrl_reg[g];
            // Only writable bits take the window value
            if (hit_wr) begin
               ctrl_next[g] = (ctrl_reg[g] & ~WM) | (i_req.wdata & WM);
            end
            // Read clears the flag in the same edge
            if (hit_rd) begin
               ctrl_next[g] = ctrl_next[g] & ~RCM;
            end
            // Hardware set wins over the read clear so no event is lost
            ctrl_next[g] = ctrl_next[g] | (i_status[g*NIB_W +: NIB_W] & RCM);
            // Forced-zero bits never hold a one
            ctrl_next[g] = ctrl_next[g] & (WM | RCM);
         end

         // A nibble moves only on its own write, its read or a flag event
         a_nib_quiet: assert property (@(posedge i_clk) disable iff (!i_arst_n)
            (!hit_wr && !hit_rd && (i_status[g*NIB_W +: NIB_W] & RCM) == 4'h0)
            |=> (ctrl_reg[g] == $past(ctrl_reg[g])))
            else $error("control nibble changed with no cause");

         // Writable bits take the window value exactly
         a_nib_write_lands: assert property (@(posedge i_clk) disable iff (!i_arst_n)
            (hit_wr && (i_status[g*NIB_W +: NIB_W] & RCM) == 4'h0)
            |=> ((ctrl_reg[g] & WM) == ($past(i_req.wdata) & WM)))
            else $error("write did not land in writable bits");
      end
   endgenerate

   // Control nibble storage
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int k = 0; k < CTRL_NIBS; k++) begin
            ctrl_reg[k] <= CTRL_RESET;
         end
      end else begin
         for (int k = 0; k < CTRL_NIBS; k++) begin
            ctrl_reg[k] <= ctrl_next[k];
         end
      end
   end

   // Peripheral-facing copy comes straight from the storage flops
   always_comb begin
      for (int k = 0; k < CTRL_NIBS; k++) begin
         o_ctrl[k*NIB_W +: NIB_W] = ctrl_reg[k];
      end
   end

   // Sequencer for alias reads, which wait on the data memory
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_reg <= ST_IDLE;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (take_rd && is_alias) begin
                  state_reg <= ST_MEM_ISSUE;
               end
            end
            ST_MEM_ISSUE: begin
               state_reg <= ST_MEM_CAPTURE;
            end
            ST_MEM_CAPTURE: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Data memory strobes, address and write data
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mem_rd_reg <= 1'b0;
         mem_wr_reg <= 1'b0;
         mem_addr_reg <= ALIAS_FIRST;
         wdata_reg <= 4'h0;
      end else begin
         mem_rd_reg <= take_rd && is_alias;
         mem_wr_reg <= take_wr && is_alias;
         if ((take_rd || take_wr) && is_alias) begin
            mem_addr_reg <= i_req.addr;
            wdata_reg <= i_req.wdata;
         end
      end
   end

   // Window register load; control reads answer in one cycle
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         window_reg <= 4'h0;
         load_reg <= 1'b0;
      end else begin
         load_reg <= 1'b0;
         if (take_rd && !is_alias) begin
            window_reg <= rd_nibble;
            load_reg <= 1'b1;
         end else if (state_reg == ST_MEM_CAPTURE) begin
            window_reg <= i_dmem_rdata;
            load_reg <= 1'b1;
         end
      end
   end

   // Busy flag, so the core holds off during an alias read
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_busy <= 1'b0;
      end else begin
         o_busy <= (take_rd && is_alias) || (state_reg == ST_MEM_ISSUE);
      end
   end

   assign o_window_data = window_reg;
   assign o_window_load = load_reg;
   assign o_dmem.rd = mem_rd_reg;
   assign o_dmem.wr = mem_wr_reg;
   assign o_dmem.addr = mem_addr_reg;
   assign o_dmem.wdata = wdata_reg;

   // Checks
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);

   logic [CTRL_BITS-1:0] ctrl_keep;
   assign ctrl_keep = o_ctrl & ~RC_MASK;

   a_ctrl_read_data: assert property (
      (take_rd && !is_alias) |=> (o_window_load && o_window_data == $past(rd_nibble)))
      else $error("control read did not load window next cycle");

   a_ctrl_write_store: assert property (
      (take_wr && !is_alias && IMPL_MAP[nib_idx] && RC_MASK[nib_idx*NIB_W +: NIB_W] == 4'h0)
      |=> (ctrl_reg[$past(nib_idx)] == ($past(i_req.wdata)
           & WR_MASK[$past(nib_idx)*NIB_W +: NIB_W])))
      else $error("control write not stored through write mask");

   a_zero_bits_hold: assert property (
      (o_ctrl & ~(WR_MASK | RC_MASK)) == '0)
      else $error("forced zero bit holds a one");

   a_unused_write: assert property (
      (take_wr && !is_alias && !IMPL_MAP[nib_idx]) |=> $stable(ctrl_keep))
      else $error("write to unused location changed a register");

   a_ro_write_ignored: assert property (
      (take_wr && !is_alias && WR_MASK[nib_idx*NIB_W +: NIB_W] == 4'h0)
      |=> $stable(ctrl_keep))
      else $error("write to read-only nibble changed state");

   a_rc_read_clears: assert property (
      (take_rd && !is_alias && RC_MASK[nib_idx*NIB_W +: NIB_W] != 4'h0
       && (i_status[nib_idx*NIB_W +: NIB_W] & RC_MASK[nib_idx*NIB_W +: NIB_W]) == 4'h0)
      |=> (ctrl_reg[$past(nib_idx)] == 4'h0))
      else $error("read-clear flag survived its read");

   a_wo_read_keeps: assert property (
      (take_rd && !is_alias) |=> $stable(ctrl_keep))
      else $error("control read disturbed a stored setting");

   a_alias_read_seq: assert property (
      (take_rd && is_alias) |=> (o_dmem.rd && o_busy) ##1 (!o_dmem.rd && o_busy)
      ##1 (o_window_load && !o_busy))
      else $error("alias read sequence wrong");

   a_alias_write_pass: assert property (
      (take_wr && is_alias) |=> (o_dmem.wr && o_dmem.addr == $past(i_req.addr)
      && o_dmem.wdata == $past(i_req.wdata) && !o_busy))
      else $error("alias write not passed to data memory");

   a_unused_not_stored: assert property (
      (o_ctrl[3:0] == 4'h0) && (o_ctrl[67:64] == 4'h0) && (o_ctrl[103:100] == 4'h0))
      else $error("unused control nibble holds data");

   a_single_cycle_load: assert property (
      (take_rd && !is_alias) |-> ##1 (o_window_load && !o_busy))
      else $error("control read took more than one cycle");

   // Dwell counter for the sequencer; an alias read must never stall the core for more than two cycles
   logic [1:0] busy_cnt_reg;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         busy_cnt_reg <= 2'h0;
      end else if (o_busy) begin
         if (busy_cnt_reg != 2'h3) begin
            busy_cnt_reg <= busy_cnt_reg + 2'h1;
         end
      end else begin
         busy_cnt_reg <= 2'h0;
      end
   end

   // Two stall cycles at most, whatever the core asks meanwhile
   a_busy_bounded: assert property (
      busy_cnt_reg <= 2'h2)
      else $error("alias read held the core too long");

   // Read wins when both strobes arrive together; the write is dropped
   a_read_beats_write: assert property (
      (i_req.rd && i_req.wr && state_reg == ST_IDLE && !is_alias)
      |=> (o_window_load && $stable(ctrl_keep)))
      else $error("simultaneous write was not dropped");

   // Requests during the alias read stall are ignored outright
   a_busy_refuses: assert property (
      (state_reg != ST_IDLE) |=> ($stable(ctrl_keep) && !o_dmem.wr))
      else $error("request taken while sequencer was busy");

   // Alias accesses never touch the control storage
   a_alias_no_ctrl: assert property (
      ((take_rd || take_wr) && is_alias) |=> $stable(ctrl_keep))
      else $error("alias access changed a control nibble");

   // Data memory only ever sees the upper half of the file
   a_dmem_upper_half: assert property (
      (o_dmem.rd || o_dmem.wr) |-> o_dmem.addr[ALIAS_BIT])
      else $error("data memory strobe outside alias half");

   // Never both strobes at once
   a_dmem_one_strobe: assert property (
      !(o_dmem.rd && o_dmem.wr))
      else $error("data memory read and write together");

   // Read strobe is a single pulse
   a_dmem_rd_pulse: assert property (
      o_dmem.rd |=> !o_dmem.rd)
      else $error("data memory read strobe stretched");

   // Busy only starts with a data memory read
   a_busy_rise_read: assert property (
      $rose(o_busy) |-> o_dmem.rd)
      else $error("busy raised without an alias read");

   // Address and data hold between alias accesses
   a_dmem_hold: assert property (
      !((take_rd || take_wr) && is_alias) |=> ($stable(o_dmem.addr) && $stable(o_dmem.wdata)))
      else $error("data memory address moved without access");

   // Alias read passes the full address
   a_alias_read_addr: assert property (
      (take_rd && is_alias) |=> (o_dmem.addr == $past(i_req.addr)))
      else $error("alias read address wrong");

   // Capture cycle copies the memory answer into the window
   a_window_from_dmem: assert property (
      (state_reg == ST_MEM_CAPTURE) |=> (o_window_data == $past(i_dmem_rdata)))
      else $error("alias read data not loaded");

   // Window keeps its value between loads
   a_window_holds: assert property (
      !o_window_load |-> $stable(o_window_data))
      else $error("window changed without a load");

   // No load pulse without a read behind it
   a_no_load_idle: assert property (
      (!take_rd && state_reg != ST_MEM_CAPTURE) |=> !o_window_load)
      else $error("window load with no read");

   // Sequencer idle means the core is free
   a_busy_from_idle: assert property (
      (state_reg == ST_IDLE) |-> !o_busy)
      else $error("busy while sequencer idle");

   // At most one transfer taken per cycle
   a_take_exclusive: assert property (
      !(take_rd && take_wr))
      else $error("read and write taken together");

   // Unused nibbles read the fixed pattern
   a_unused_read_value: assert property (
      (take_rd && !is_alias && !IMPL_MAP[nib_idx]) |=> (o_window_data == UNDEF_READ))
      else $error("unused nibble read wrong value");

   // Write-only and forced-zero bits never leak into the window
   a_wo_bits_hidden: assert property (
      (take_rd && !is_alias && IMPL_MAP[nib_idx])
      |=> ((o_window_data & ~(RD_MASK[$past(nib_idx)*NIB_W +: NIB_W]
           | RC_MASK[$past(nib_idx)*NIB_W +: NIB_W]
           | HW_MASK[$past(nib_idx)*NIB_W +: NIB_W])) == 4'h0))
      else $error("hidden bit showed in window");

   // A flag event in the read cycle survives the clear
   a_rc_set_wins: assert property (
      ((i_status & RC_MASK) != '0)
      |=> ((o_ctrl & $past(i_status) & RC_MASK) == ($past(i_status) & RC_MASK)))
      else $error("flag event lost to read clear");

   c_rc_read: cover property (take_rd && !is_alias && RC_MASK[nib_idx*NIB_W +: NIB_W] != 4'h0);
   c_alias_read: cover property (take_rd && is_alias ##3 o_window_load);
   c_alias_write: cover property (take_wr && is_alias);
   c_ro_write: cover property (take_wr && !is_alias && WR_MASK[nib_idx*NIB_W +: NIB_W] == 4'h0);
   c_set_wins: cover property (take_rd && !is_alias
      && (i_status[nib_idx*NIB_W +: NIB_W] & RC_MASK[nib_idx*NIB_W +: NIB_W]) != 4'h0);

endmodule

/* rtl/rf_pkg.sv */
// Shared constants and types for the peripheral control register file
package rf_pkg;
   // Address space: 8 rows of 16 nibble columns
   localparam int ADDR_W = 7;
   localparam int NIB_W = 4;
   localparam int CTRL_NIBS = 64;
   localparam int CTRL_BITS = 256;
   localparam int ROW_MAX = 7;
   localparam int COL_MAX = 15;
   // Top address bit selects the data memory alias half (40h..7fh)
   localparam int ALIAS_BIT = 6;
   localparam logic [ADDR_W-1:0] CTRL_FIRST = 7'h00;
   localparam logic [ADDR_W-1:0] CTRL_LAST = 7'h3f;
   localparam logic [ADDR_W-1:0] ALIAS_FIRST = 7'h40;
   localparam logic [ADDR_W-1:0] ALIAS_LAST = 7'h7f;

   // Control nibbles that exist; 00h, 10h and 19h are unused
   localparam logic [CTRL_NIBS-1:0] IMPL_MAP = 64'hffff_ffff_fdfe_fffe;
   // Bits software may write, one nibble per address, 3fh at the left
   localparam logic [CTRL_BITS-1:0] WR_MASK =
      256'h111111fffff0ff1f_fff111101ff7f071_700f330f0077f070_3073ff1f0bff10f0;
   // Stored bits that read back (read/write bits, not write-only ones)
   localparam logic [CTRL_BITS-1:0] RD_MASK =
      256'h111111fffff0ff1f_fff111101ff7f071_700f030f0077f070_3043ff1f02ff10f0;
   // Read-only bits that show live peripheral state
   localparam logic [CTRL_BITS-1:0] HW_MASK =
      256'h2200000000000000_0002000f00080000_0000000000000010_0100000010000000;
   // Flag bits that hardware sets and a read clears
   localparam logic [CTRL_BITS-1:0] RC_MASK =
      256'h0000000000010000_0000000000000100_0110000011000000_0000000000000100;

   // Reset value of every stored control nibble
   localparam logic [NIB_W-1:0] CTRL_RESET = 4'h0;
   // Value returned for unused or write-only bits
   localparam logic [NIB_W-1:0] UNDEF_READ = 4'h0;
   // Cycles from taking a data memory read to the window load
   localparam int MEM_READ_CYCLES = 3;

   // One transfer request from the core
   typedef struct packed {
      logic rd;
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [NIB_W-1:0] wdata;
   } rf_req_t;

   // Access to the current data memory bank
   typedef struct packed {
      logic rd;
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [NIB_W-1:0] wdata;
   } dmem_req_t;
endpackage

/* test/dmem_model.sv */
// Data memory bank model answering the register file alias window
`timescale 1ns/100ps
module dmem_model
   import rf_pkg::*;
(
   input wire logic i_clk,
   input wire dmem_req_t i_dmem,
   output logic [NIB_W-1:0] o_rdata
);
   logic [NIB_W-1:0] mem_reg [0:63];
   logic [NIB_W-1:0] rdata_reg = 4'h0;
   // Store on write pulse, answer a read on the following cycle
   always_ff @(posedge i_clk) begin
      if (i_dmem.wr) begin
         mem_reg[i_dmem.addr[5:0]] <= i_dmem.wdata;
      end
      // Toggles outside the valid cycle so stale data never looks right
      rdata_reg <= i_dmem.rd ? mem_reg[i_dmem.addr[5:0]] : ~rdata_reg;
   end
   assign o_rdata = rdata_reg;
endmodule

/* test/tb.sv */
// Self-checking bench for the peripheral control register file
`timescale 1ns/100ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin errors++; \
   $display("[ERR] t=%0t got %h exp %h", $time, got, exp); end end
module tb;
   import rf_pkg::*;
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   rf_req_t i_req = '0;
   logic [CTRL_BITS-1:0] i_status = '0;
   logic [NIB_W-1:0] i_dmem_rdata;
   logic [NIB_W-1:0] o_window_data;
   logic o_window_load;
   logic o_busy;
   dmem_req_t o_dmem;
   logic [CTRL_BITS-1:0] o_ctrl;
   logic [NIB_W-1:0] got;
   logic [NIB_W-1:0] exp_nib;
   logic [CTRL_BITS-1:0] exp_ctrl = '0;
   int errors = 0;
   int tests_run = 0;

   always #4 i_clk = ~i_clk;

   peripheral_control_register_file u_dut (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_req(i_req),
      .i_status(i_status),
      .i_dmem_rdata(i_dmem_rdata),
      .o_window_data(o_window_data),
      .o_window_load(o_window_load),
      .o_busy(o_busy),
      .o_dmem(o_dmem),
      .o_ctrl(o_ctrl)
   );

   dmem_model u_mem (
      .i_clk(i_clk),
      .i_dmem(o_dmem),
      .o_rdata(i_dmem_rdata)
   );

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Request stays up after the taking edge so writes can go back to back
   task automatic issue(input logic rd, input logic [ADDR_W-1:0] addr,
                        input logic [NIB_W-1:0] d);
      i_req = '{rd: rd, wr: ~rd, addr: addr, wdata: d};
      @(posedge i_clk);
      #1;
   endtask

   // Read into the window, bounded wait for the load pulse
   task automatic rd_win(input logic [ADDR_W-1:0] addr, output logic [NIB_W-1:0] q);
      int n;
      n = 0;
      issue(1'b1, addr, 4'h0);
      i_req.rd = 1'b0;
      while (o_window_load !== 1'b1 && n < 6) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      if (n == 6) begin
         errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, 1'b0, 1'b1);
      end
      q = o_window_data;
      @(posedge i_clk);
      #1;
   endtask

   initial begin
      repeat (10) @(posedge i_clk);
      #1;
      i_arst_n = 1'b1;
      `CHK(o_ctrl, exp_ctrl)
      `CHK(o_window_load, 1'b0)
      // All-ones into every control nibble; only writable bits may land
      for (int a = 0; a < CTRL_NIBS; a++) begin
         issue(1'b0, a[ADDR_W-1:0], 4'hf);
         exp_ctrl[4*a +: 4] = WR_MASK[4*a +: 4];
         `CHK(o_ctrl, exp_ctrl)
      end
      // Plain, then flags and live state, then flags already cleared
      for (int ph = 0; ph < 3; ph++) begin
         if (ph == 1) begin
            i_status = RC_MASK;
            @(posedge i_clk);
            #1;
            i_status = HW_MASK;
         end
         for (int a = 0; a < CTRL_NIBS; a++) begin
            rd_win(a[ADDR_W-1:0], got);
            exp_nib = (WR_MASK[4*a +: 4] & RD_MASK[4*a +: 4])
                    | (ph > 0 ? HW_MASK[4*a +: 4] : 4'h0)
                    | (ph == 1 ? RC_MASK[4*a +: 4] : 4'h0);
            `CHK(got, exp_nib)
         end
      end
      `CHK(o_ctrl & WR_MASK, exp_ctrl)
      // Alias window at both ends of the upper half
      issue(1'b0, ALIAS_FIRST, 4'h9);
      `CHK(o_dmem.wr, 1'b1)
      `CHK(o_dmem.addr, ALIAS_FIRST)
      `CHK(o_dmem.wdata, 4'h9)
      issue(1'b0, ALIAS_LAST, 4'h6);
      rd_win(ALIAS_FIRST, got);
      `CHK(got, 4'h9)
      rd_win(ALIAS_LAST, got);
      `CHK(got, 4'h6)
      // Alias read walk; a write held during the stall must be refused
      issue(1'b1, ALIAS_LAST, 4'h0);
      `CHK({o_dmem.rd, o_busy, o_dmem.addr}, {1'b1, 1'b1, ALIAS_LAST})
      i_req = '{rd: 1'b0, wr: 1'b1, addr: 7'h01, wdata: 4'h5};
      @(posedge i_clk);
      #1;
      `CHK({o_dmem.rd, o_busy, o_window_load}, 3'b010)
      @(posedge i_clk);
      #1;
      i_req = '0;
      `CHK({o_window_load, o_busy, o_window_data}, 6'h26)
      `CHK(o_ctrl[7:4], 4'hf)
      // Read and write together: the read wins, the write is dropped
      i_req = '{rd: 1'b1, wr: 1'b1, addr: 7'h01, wdata: 4'h3};
      @(posedge i_clk);
      #1;
      i_req = '0;
      `CHK({o_window_load, o_window_data}, 5'h1f)
      `CHK(o_ctrl & WR_MASK, exp_ctrl)
      // Flag event in the cycle of its read: old value out, flag kept
      i_status = HW_MASK | RC_MASK;
      rd_win(7'h02, got);
      i_status = HW_MASK;
      `CHK(got, HW_MASK[11:8])
      rd_win(7'h02, got);
      `CHK(got, RC_MASK[11:8] | HW_MASK[11:8])
      tally_and_finish();
   end

   // Whole run is under a thousand cycles; this leaves a wide margin
   initial begin
      #50000;
      errors++;
      tally_and_finish();
   end
endmodule
